// ---- design/ppm_params.svh ----
// Offsets, field positions, reset values and timing counts of the port power manager
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

`define PPM_CLK_HZ            20000000
`define PPM_ADDR_CTRL         12'h000
`define PPM_ADDR_PRIO         12'h004
`define PPM_ADDR_REMAP        12'h008
`define PPM_ADDR_STATUS       12'h00C
`define PPM_ADDR_AUTOCLASS    12'h010
`define PPM_ADDR_CLASS        12'h014
`define PPM_ADDR_CURRENT      12'h018
`define PPM_ADDR_VSUPPLY      12'h01C
`define PPM_ADDR_DETEN        12'h020
`define PPM_ADDR_CFGLOAD      12'h024
`define PPM_CTRL_MULTIBIT     0
`define PPM_CTRL_AC_REQ_PHY   1
`define PPM_CTRL_AC_REQ_LLDP  2
`define PPM_CTRL_ON_LSB       4
`define PPM_REMAP_RESET       8'hE4
`define PPM_TEMP_SHUT_C       150
`define PPM_TEMP_RESUME_C     125
`define PPM_AUTOCLASS_START_MS 1500
`define PPM_AUTOCLASS_END_MS   1800
`define PPM_AUTOCLASS_WIN_MS   230
`define PPM_AVG_WIN_MS         1000
`define PPM_AVG_UPD_MS         100
`define PPM_SHED_LATENCY_NS    6500
`define PPM_CYC_PER_MS         (`PPM_CLK_HZ / 1000)
`define PPM_SHED_LATENCY_CYC   ((`PPM_SHED_LATENCY_NS * (`PPM_CLK_HZ / 1000000)) / 1000)
`define PPM_CLASS_EARLY_CYC    20
`define PPM_CLASS_SETTLE_CYC   40
`define PPM_CLASS_LATE_CYC     20
`define PPM_SHED_BIT_CYC       8

`endif

// ---- design/ppm_pkg.sv ----
// Types of the port power manager
package ppm_pkg;
	typedef enum logic [2:0] {PPM_CL_IDLE, PPM_CL_EARLY, PPM_CL_SETTLE, PPM_CL_LATE} ppm_class_st_t;
	typedef enum logic [1:0] {PPM_AC_IDLE, PPM_AC_WAIT, PPM_AC_MEAS} ppm_ac_st_t;
	typedef enum logic [1:0] {PPM_SH_IDLE, PPM_SH_START, PPM_SH_BITS} ppm_shed_st_t;
	typedef logic [1:0] ppm_remap_t [4];
endpackage : ppm_pkg

// ---- design/ppm_port_power_manager.sv ----
// Port power manager: classification, autoclass, averaging, thermal and supply shedding, remap
// Behaviour
// - Early in first class event, measure class current as normal class result.
// - Keep first class event running without sampling during settling.
// - Sample late; class 0 means autoclass request; then end the event.
// - Physical-layer autoclass starts measuring 1.5 s after inrush completes.
// - Link-layer autoclass request starts measuring at once.
// - Over 1.8 s sample current and voltage; keep max 0.23 s window power.
// - Autoclass result placed in a single readable register for the measured port.
// - Reported current is zero whenever the channel is off.
// - Moving one-second current average, refreshed every 100 ms.
// - Supply voltage sampled aligned with the port 1 current samples.
// - Thermal shutdown above 150 C, restart blocked until below 125 C.
// - Priority mode field selects single-bit or three-bit shedding.
// - Single-bit mode: shed-pin rise turns off low-priority ports within 6.5 us.
// - Each shed event sets shed flag and disconnect flag.
// - Three-bit mode: turn off ports with priority at or below received code.
// - Shed ports keep their detection enables set.
// - Remap entry is two bits, 00b port 1 through 11b port 4.
// - Reset remap is identity.
// - Any one-to-one mapping allowed; logical 1-2 and 3-4 pair for four-pair.
// - At boot load stored defaults; power profile pins may be overridden.
`timescale 1ns/100ps
`include "ppm_params.svh"
module ppm_port_power_manager
	import ppm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins and analog front end
	input  wire logic        supply_shed_pin,
	input  wire logic [1:0]  power_profile_pins,
	input  wire logic        boot_cfg_valid,
	input  wire logic [31:0] boot_cfg_word,
	input  wire logic [3:0]  sample_strobe,
	input  wire logic [15:0] port_current [4],
	input  wire logic [15:0] negative_supply_voltage,
	input  wire logic [7:0]  die_temp_c,
	input  wire logic [3:0]  inrush_done,
	input  wire logic        class_start,
	input  wire logic [2:0]  class_sig,
	// Port outputs
	output logic      [3:0]  port_power_en,
	output logic      [3:0]  port_power_phys,
	output logic      [1:0]  power_profile,
	output logic             class_active
);
	import ppm_pkg::*;

	typedef struct packed {
		logic [2:0]  shed_sync;
		logic [3:0]  on;
		logic        multibit;
		logic [3:0]  lowprio;
		logic [11:0] prio3;
		logic [7:0]  remap;
		logic [3:0]  det_en;
		logic        shed_flag;
		logic        disc_flag;
		logic        overtemp;
		logic [1:0]  profile;
		logic        booted;
		ppm_class_st_t cl_st;
		logic [7:0]  cl_cnt;
		logic [2:0]  class_res;
		logic        ac_requested;
		ppm_ac_st_t  ac_st;
		logic [1:0]  ac_port;
		logic [35:0] ac_cnt;
		logic [31:0] ac_win_acc;
		logic [31:0] ac_max;
		logic [31:0] ac_result;
		logic [31:0] ac_win_cnt;
		logic [31:0] avg_cnt;
		logic [43:0] avg_acc;
		logic [15:0] avg_out;
		logic [15:0] vsup;
		ppm_shed_st_t sh_st;
		logic [7:0]  sh_cnt;
		logic [1:0]  sh_bit;
		logic [2:0]  sh_code;
		logic [15:0] sh_lat;
	} ppm_state_t;

	ppm_state_t s_q, s_d;

	localparam logic [35:0] AC_WAIT_CYC = 36'(`PPM_AUTOCLASS_START_MS * `PPM_CYC_PER_MS);
	localparam logic [35:0] AC_MEAS_CYC = 36'(`PPM_AUTOCLASS_END_MS * `PPM_CYC_PER_MS);
	localparam logic [31:0] AC_WIN_CYC  = 32'(`PPM_AUTOCLASS_WIN_MS * `PPM_CYC_PER_MS);
	localparam logic [31:0] AVG_UPD_CYC = 32'(`PPM_AVG_UPD_MS * `PPM_CYC_PER_MS);
	localparam logic [3:0]  AVG_SLOTS   = 4'(`PPM_AVG_WIN_MS / `PPM_AVG_UPD_MS);

	// Checks a 4-entry remap for a physical port used twice
	function automatic logic remap_ok(input logic [7:0] m);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			for (int j = i + 1; j < 4; j++) begin
				if (m[2*i +: 2] == m[2*j +: 2]) begin
					ok = 1'b0;
				end
			end
		end
		return ok;
	endfunction : remap_ok

	wire logic shed_lvl  = s_q.shed_sync[1];
	wire logic shed_rise = s_q.shed_sync[1] & ~s_q.shed_sync[2];
	wire logic apb_wr    = psel & penable & pwrite;
	wire logic [15:0] slot_sum = port_current[0];

	// Ten 100 ms slots form the one-second moving average
	logic [15:0] slot_q [10];
	logic [3:0]  slot_ptr_q;
	logic        slot_tick;
	assign slot_tick = (s_q.avg_cnt == AVG_UPD_CYC - 32'h1);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			slot_ptr_q <= 4'h0;
			for (int k = 0; k < 10; k++) begin
				slot_q[k] <= 16'h0000;
			end
		end else if (slot_tick) begin
			slot_q[slot_ptr_q] <= s_q.avg_acc[15:0];
			slot_ptr_q <= (slot_ptr_q == AVG_SLOTS - 4'h1) ? 4'h0 : slot_ptr_q + 4'h1;
		end
	end

	logic [19:0] slot_total;
	always_comb begin
		slot_total = 20'h00000;
		for (int k = 0; k < 10; k++) begin
			slot_total = slot_total + 20'(slot_q[k]);
		end
	end

	always_comb begin
		logic [15:0] pwr;
		logic [2:0]  lvl;
		pwr = 16'h0000;
		lvl = 3'h0;
		s_d = s_q;
		s_d.shed_sync = {s_q.shed_sync[1:0], supply_shed_pin};

		// Boot load of stored defaults; profile pins are the fallback only
		if (!s_q.booted) begin
			s_d.booted = 1'b1;
			s_d.profile = power_profile_pins;
			if (boot_cfg_valid) begin
				s_d.profile  = boot_cfg_word[1:0];
				s_d.multibit = boot_cfg_word[2];
				if (remap_ok(boot_cfg_word[15:8])) begin
					s_d.remap = boot_cfg_word[15:8];
				end
			end
		end

		// Register writes
		if (apb_wr) begin
			unique case (paddr)
				`PPM_ADDR_CTRL: begin
					s_d.multibit = pwdata[`PPM_CTRL_MULTIBIT];
					s_d.ac_requested = pwdata[`PPM_CTRL_AC_REQ_PHY];
					if (pwdata[`PPM_CTRL_AC_REQ_LLDP]) begin
						s_d.ac_st = PPM_AC_MEAS;
						s_d.ac_cnt = 36'h0;
						s_d.ac_win_cnt = 32'h0;
						s_d.ac_win_acc = 32'h0;
						s_d.ac_max = 32'h0;
						s_d.ac_port = pwdata[9:8];
					end
					s_d.on = pwdata[`PPM_CTRL_ON_LSB +: 4] & {4{~s_q.overtemp}};
				end
				`PPM_ADDR_PRIO: begin
					s_d.lowprio = pwdata[3:0];
					s_d.prio3 = pwdata[19:8];
				end
				`PPM_ADDR_REMAP: begin
					if (remap_ok(pwdata[7:0])) begin
						s_d.remap = pwdata[7:0];
					end
				end
				`PPM_ADDR_DETEN: s_d.det_en = pwdata[3:0];
				`PPM_ADDR_STATUS: begin
					if (pwdata[0]) s_d.shed_flag = 1'b0;
					if (pwdata[1]) s_d.disc_flag = 1'b0;
				end
				default: ;
			endcase
		end

		// Thermal protection with hysteresis
		if (die_temp_c > 8'(`PPM_TEMP_SHUT_C)) begin
			s_d.overtemp = 1'b1;
			s_d.on = 4'h0;
		end else if (die_temp_c < 8'(`PPM_TEMP_RESUME_C)) begin
			s_d.overtemp = 1'b0;
		end

		// Classification: early sample, silent settle, late autoclass sample
		unique case (s_q.cl_st)
			PPM_CL_IDLE: if (class_start) begin
				s_d.cl_st = PPM_CL_EARLY;
				s_d.cl_cnt = 8'h00;
			end
			PPM_CL_EARLY: begin
				s_d.cl_cnt = s_q.cl_cnt + 8'h01;
				if (s_q.cl_cnt == 8'(`PPM_CLASS_EARLY_CYC - 1)) begin
					s_d.class_res = class_sig;
					s_d.cl_st = PPM_CL_SETTLE;
					s_d.cl_cnt = 8'h00;
				end
			end
			PPM_CL_SETTLE: begin
				s_d.cl_cnt = s_q.cl_cnt + 8'h01;
				if (s_q.cl_cnt == 8'(`PPM_CLASS_SETTLE_CYC - 1)) begin
					s_d.cl_st = PPM_CL_LATE;
					s_d.cl_cnt = 8'h00;
				end
			end
			PPM_CL_LATE: begin
				s_d.cl_cnt = s_q.cl_cnt + 8'h01;
				if (s_q.cl_cnt == 8'(`PPM_CLASS_LATE_CYC - 1)) begin
					s_d.ac_requested = (class_sig == 3'h0);
					s_d.cl_st = PPM_CL_IDLE;
				end
			end
			default: s_d.cl_st = PPM_CL_IDLE;
		endcase

		// Autoclass power measurement
		pwr = 16'((32'(port_current[s_q.ac_port]) * 32'(negative_supply_voltage)) >> 16);
		unique case (s_q.ac_st)
			PPM_AC_IDLE: if (s_q.ac_requested && inrush_done[s_q.ac_port]) begin
				s_d.ac_st = PPM_AC_WAIT;
				s_d.ac_cnt = 36'h0;
			end
			PPM_AC_WAIT: begin
				s_d.ac_cnt = s_q.ac_cnt + 36'h1;
				if (s_q.ac_cnt == AC_WAIT_CYC - 36'h1) begin
					s_d.ac_st = PPM_AC_MEAS;
					s_d.ac_cnt = 36'h0;
					s_d.ac_win_cnt = 32'h0;
					s_d.ac_win_acc = 32'h0;
					s_d.ac_max = 32'h0;
				end
			end
			PPM_AC_MEAS: begin
				s_d.ac_requested = 1'b0;
				s_d.ac_cnt = s_q.ac_cnt + 36'h1;
				s_d.ac_win_acc = s_q.ac_win_acc + 32'(pwr);
				s_d.ac_win_cnt = s_q.ac_win_cnt + 32'h1;
				if (s_q.ac_win_cnt == AC_WIN_CYC - 32'h1) begin
					if (s_q.ac_win_acc > s_q.ac_max) s_d.ac_max = s_q.ac_win_acc;
					s_d.ac_win_cnt = 32'h0;
					s_d.ac_win_acc = 32'h0;
				end
				if (s_q.ac_cnt == AC_MEAS_CYC - 36'h1) begin
					s_d.ac_result = s_q.ac_max;
					s_d.ac_st = PPM_AC_IDLE;
				end
			end
			default: s_d.ac_st = PPM_AC_IDLE;
		endcase

		// Current averaging and supply voltage sampled on the same strobe
		s_d.avg_cnt = slot_tick ? 32'h0 : s_q.avg_cnt + 32'h1;
		if (slot_tick) begin
			s_d.avg_acc = 44'h0;
			s_d.avg_out = 16'(slot_total / 20'(AVG_SLOTS));
		end else if (sample_strobe[0]) begin
			s_d.avg_acc = s_q.avg_acc + 44'(slot_sum >> 4);
		end
		if (sample_strobe[0]) begin
			s_d.vsup = negative_supply_voltage;
		end

		// Shed pin: edge in single-bit mode, start plus three bits in three-bit mode
		if (!s_q.multibit) begin
			s_d.sh_st = PPM_SH_IDLE;
			if (shed_rise) begin
				s_d.on = s_q.on & ~s_q.lowprio;
				s_d.shed_flag = 1'b1;
				s_d.disc_flag = 1'b1;
			end
		end else begin
			unique case (s_q.sh_st)
				PPM_SH_IDLE: if (shed_rise) begin
					s_d.sh_st = PPM_SH_START;
					s_d.sh_cnt = 8'h00;
				end
				PPM_SH_START: begin
					s_d.sh_cnt = s_q.sh_cnt + 8'h01;
					if (s_q.sh_cnt == 8'(`PPM_SHED_BIT_CYC + `PPM_SHED_BIT_CYC / 2 - 1)) begin
						s_d.sh_st = PPM_SH_BITS;
						s_d.sh_cnt = 8'h00;
						s_d.sh_bit = 2'h0;
						s_d.sh_code = {s_q.sh_code[1:0], shed_lvl};
					end
				end
				PPM_SH_BITS: begin
					s_d.sh_cnt = s_q.sh_cnt + 8'h01;
					if (s_q.sh_cnt == 8'(`PPM_SHED_BIT_CYC - 1)) begin
						s_d.sh_cnt = 8'h00;
						s_d.sh_code = {s_q.sh_code[1:0], shed_lvl};
						s_d.sh_bit = s_q.sh_bit + 2'h1;
						if (s_q.sh_bit == 2'h1) begin
							for (int p = 0; p < 4; p++) begin
								lvl = s_q.prio3[3*p +: 3];
								if (lvl <= {s_q.sh_code[1:0], shed_lvl}) s_d.on[p] = 1'b0;
							end
							s_d.shed_flag = 1'b1;
							s_d.disc_flag = 1'b1;
							s_d.sh_st = PPM_SH_IDLE;
						end
					end
				end
				default: s_d.sh_st = PPM_SH_IDLE;
			endcase
		end
		// Shedding clears only the enables, so det_en stays set and the port redetects
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.remap <= `PPM_REMAP_RESET;
			s_q.det_en <= 4'hF;
			s_q.cl_st <= PPM_CL_IDLE;
			s_q.ac_st <= PPM_AC_IDLE;
			s_q.sh_st <= PPM_SH_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Physical enables through the remap table
	always_comb begin
		port_power_phys = 4'h0;
		for (int l = 0; l < 4; l++) begin
			if (s_q.on[l]) port_power_phys[s_q.remap[2*l +: 2]] = 1'b1;
		end
	end

	assign port_power_en = s_q.on;
	assign power_profile = s_q.profile;
	assign class_active  = (s_q.cl_st != PPM_CL_IDLE);
	assign pready        = 1'b1;

	always_comb begin
		prdata  = 32'h0;
		pslverr = 1'b0;
		// Unmapped addresses are refused on writes as well as reads
		if (psel && penable) begin
			unique case (paddr)
				`PPM_ADDR_CTRL:      prdata = {24'h0, s_q.on, 1'b0, 1'b0, s_q.ac_requested, s_q.multibit};
				`PPM_ADDR_PRIO:      prdata = {12'h0, s_q.prio3, 4'h0, s_q.lowprio};
				`PPM_ADDR_REMAP:     prdata = {24'h0, s_q.remap};
				`PPM_ADDR_STATUS:    prdata = {28'h0, s_q.overtemp, 1'b0, s_q.disc_flag, s_q.shed_flag};
				`PPM_ADDR_AUTOCLASS: prdata = s_q.ac_result;
				`PPM_ADDR_CLASS:     prdata = {29'h0, s_q.class_res};
				`PPM_ADDR_CURRENT:   prdata = s_q.on[0] ? {16'h0, s_q.avg_out} : 32'h0;
				`PPM_ADDR_VSUPPLY:   prdata = {16'h0, s_q.vsup};
				`PPM_ADDR_DETEN:     prdata = {28'h0, s_q.det_en};
				`PPM_ADDR_CFGLOAD:   prdata = {29'h0, s_q.booted, s_q.profile};
				default:             pslverr = 1'b1;
			endcase
		end
	end
endmodule : ppm_port_power_manager

// ---- verification/ppm_chk.sv ----
// Concurrent checks on the port power manager ports
`timescale 1ns/100ps
module ppm_chk (
	// Clock and reset
	input logic        clk,
	input logic        sys_rst,
	// APB
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// Pins and port state
	input logic        supply_shed_pin,
	input logic [3:0]  sample_strobe,
	input logic [15:0] negative_supply_voltage,
	input logic [7:0]  die_temp_c,
	input logic [3:0]  port_power_en,
	input logic [3:0]  port_power_phys,
	input logic        class_active
);
	logic       mb_q;
	logic [3:0] lowp_q;
	logic       hot_q;
	logic [7:0] cls_q;
	logic [15:0] vs_q;

	// Mode and priority shadowed from APB writes, since the checker cannot see registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mb_q <= 1'b0;
			lowp_q <= 4'h0;
			hot_q <= 1'b0;
			cls_q <= 8'h00;
			vs_q <= 16'h0000;
		end else begin
			if (sample_strobe[0]) vs_q <= negative_supply_voltage;
			if (psel && penable && pwrite && paddr == 12'h000) mb_q <= pwdata[0];
			if (psel && penable && pwrite && paddr == 12'h004) lowp_q <= pwdata[3:0];
			if (die_temp_c > 8'd150) hot_q <= 1'b1;
			else if (die_temp_c < 8'd125) hot_q <= 1'b0;
			cls_q <= class_active ? cls_q + 8'h01 : 8'h00;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence acc_s; psel && penable; endsequence
	sequence hot_s; (die_temp_c > 8'd150) [*2]; endsequence
	sequence shed_s; !mb_q && $rose(supply_shed_pin); endsequence

	a_ready_zero_wait: assert property (acc_s |-> pready)
		else $error("pready low in access phase");
	a_err_unmapped: assert property (acc_s ##0 (paddr > 12'h024 || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (acc_s ##0 (paddr <= 12'h024 && paddr[1:0] == 2'h0) |-> !pslverr)
		else $error("error on mapped address");
	a_current_off: assert property (acc_s ##0 (!pwrite && paddr == 12'h018 && !port_power_en[0]) |-> prdata == 32'h0)
		else $error("current reported while channel off");
	a_vsup_read: assert property (acc_s ##0 (!pwrite && paddr == 12'h01C) |-> prdata[15:0] == vs_q)
		else $error("supply voltage not taken on the sample strobe");
	a_class_length: assert property ($fell(class_active) |-> cls_q == 8'd80)
		else $error("class event length wrong");
	a_temp_off: assert property (hot_s |-> ##[0:3] port_power_en == 4'h0)
		else $error("ports still on when hot");
	a_temp_hold: assert property (hot_q && $past(hot_q, 4) |-> port_power_en == 4'h0)
		else $error("port restarted before cooling");
	a_phys_count: assert property ($countones(port_power_phys) == $countones(port_power_en))
		else $error("remap lost or doubled a port");
	a_shed_single: assert property (shed_s |-> ##[1:130] (port_power_en & lowp_q) == 4'h0)
		else $error("low priority ports not shed in time");
endmodule : ppm_chk

bind ppm_port_power_manager ppm_chk i_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.supply_shed_pin(supply_shed_pin), .sample_strobe(sample_strobe),
	.negative_supply_voltage(negative_supply_voltage), .die_temp_c(die_temp_c), .port_power_en(port_power_en),
	.port_power_phys(port_power_phys), .class_active(class_active));

// ---- verification/ppm_pd_model.sv ----
// Powered device class signature model
`timescale 1ns/100ps
module ppm_pd_model (
	// Clock and reset
	input  logic       clk,
	input  logic       sys_rst,
	// Class event
	input  logic       class_active,
	input  logic       want_autoclass,
	input  logic [2:0] base_class,
	output logic [2:0] class_sig
);
	logic [7:0] cnt_q;
	logic [2:0] idle_q;

	// Outside a class event nothing is presented, so the level keeps changing
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
			idle_q <= 3'h5;
		end else begin
			cnt_q <= class_active ? cnt_q + 8'h01 : 8'h00;
			idle_q <= ~idle_q;
		end
	end

	// Switch to class 0 midway through settling and hold to the end of the event
	assign class_sig = !class_active ? idle_q : (want_autoclass && cnt_q >= 8'd40) ? 3'h0 : base_class;
endmodule : ppm_pd_model

// ---- verification/pse_port_power_manager_test.sv ----
// Self-checking testbench of the port power manager
`timescale 1ns/100ps
`include "ppm_params.svh"
module pse_port_power_manager_test;
	import ppm_pkg::*;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} ppm_note_t;
	logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rnd;
	logic        pready, pslverr, shed = 1'b0, class_start = 1'b0, want = 1'b0, class_active;
	logic [2:0]  base = 3'h0, class_sig;
	logic [7:0]  temp = 8'h19;
	logic [15:0] cur [4] = '{default: 16'h0};
	logic [15:0] vneg = 16'h0;
	logic [3:0]  strobe = 4'h0, en, phys, exp_en;
	logic [1:0]  profile;
	ppm_note_t   notes [$];
	ppm_note_t   nt;
	int          bad_count = 0, n_checks = 0, seed = 88;

	always #25 clk = ~clk;

	ppm_port_power_manager i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_shed_pin(shed), .power_profile_pins(2'h1), .boot_cfg_valid(1'b1), .boot_cfg_word(32'h0000E402),
		.sample_strobe(strobe), .port_current(cur), .negative_supply_voltage(vneg), .die_temp_c(temp),
		.inrush_done(4'hF), .class_start(class_start), .class_sig(class_sig), .port_power_en(en),
		.port_power_phys(phys), .power_profile(profile), .class_active(class_active));

	ppm_pd_model i_pd (.clk(clk), .sys_rst(sys_rst), .class_active(class_active), .want_autoclass(want),
		.base_class(base), .class_sig(class_sig));

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// One idle cycle after each transfer keeps psel from being assigned twice in a time step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
		notes.push_back('{d & m, m, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	// Start bit, then three code bits MSB first, eight clocks each
	task automatic send_code(input logic [2:0] c);
		shed <= 1'b1;
		repeat (8) @(posedge clk);
		for (int i = 2; i >= 0; i--) begin
			shed <= c[i];
			repeat (8) @(posedge clk);
		end
		shed <= 1'b0;
		repeat (16) @(posedge clk);
	endtask : send_code

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out

	// Random analog samples keep the averaging and supply paths busy
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			rnd = $random(seed);
			cur[i] <= rnd[15:0] | 16'h0001;
		end
		vneg <= rnd[31:16];
		strobe <= rnd[19:16];
	end

	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite && notes.size() > 0) begin
			nt = notes.pop_front();
			check("prdata", prdata & nt.m, nt.d);
			check("pslverr", {31'h0, pslverr}, {31'h0, nt.e});
		end
	end

	initial begin
		#(20000 * 50);
		bad_count++;
		close_out();
	end

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		check("power_profile", {30'h0, profile}, 32'h2);
		rd(`PPM_ADDR_REMAP, 32'hE4, 32'hFF, 1'b0);
		rd(12'h030, 32'h0, 32'h0, 1'b1);
		$display("test boot done");
		wr(`PPM_ADDR_CTRL, 32'h10);
		wr(`PPM_ADDR_REMAP, 32'h1B);
		rd(`PPM_ADDR_REMAP, 32'h1B, 32'hFF, 1'b0);
		check("phys", {28'h0, phys}, 32'h8);
		wr(`PPM_ADDR_REMAP, 32'h00);
		rd(`PPM_ADDR_REMAP, 32'h1B, 32'hFF, 1'b0);
		wr(`PPM_ADDR_REMAP, 32'hE4);
		wr(`PPM_ADDR_CTRL, 32'h0);
		rd(`PPM_ADDR_CURRENT, 32'h0, 32'hFFFFFFFF, 1'b0);
		rd(`PPM_ADDR_VSUPPLY, 32'h0, 32'h0, 1'b0);
		$display("test remap done");
		for (int k = 0; k < 2; k++) begin
			want <= k[0];
			base <= 3'h2 + k[2:0];
			class_start <= 1'b1;
			@(posedge clk);
			class_start <= 1'b0;
			repeat (90) @(posedge clk);
			rd(`PPM_ADDR_CLASS, 32'h2 + k, 32'h7, 1'b0);
			rd(`PPM_ADDR_CTRL, 32'h2 * k, 32'h2, 1'b0);
		end
		$display("test class done");
		wr(`PPM_ADDR_PRIO, 32'h5);
		wr(`PPM_ADDR_CTRL, 32'hF0);
		shed <= 1'b1;
		repeat (130) @(posedge clk);
		check("shed single", {28'h0, en}, 32'hA);
		rd(`PPM_ADDR_STATUS, 32'h3, 32'h3, 1'b0);
		rd(`PPM_ADDR_DETEN, 32'hF, 32'hF, 1'b0);
		shed <= 1'b0;
		wr(`PPM_ADDR_STATUS, 32'h3);
		rd(`PPM_ADDR_STATUS, 32'h0, 32'h3, 1'b0);
		$display("test single shed done");
		wr(`PPM_ADDR_PRIO, 32'h000F5900);
		for (int c = 0; c < 8; c++) begin
			wr(`PPM_ADDR_CTRL, 32'hF1);
			send_code(c[2:0]);
			for (int i = 0; i < 4; i++) exp_en[i] = (2 * i + 1) > c;
			check("shed code", {28'h0, en}, {28'h0, exp_en});
			rd(`PPM_ADDR_STATUS, 32'h3, 32'h3, 1'b0);
			wr(`PPM_ADDR_STATUS, 32'h3);
		end
		$display("test multibit shed done");
		wr(`PPM_ADDR_CTRL, 32'hF0);
		temp <= 8'd151;
		repeat (6) @(posedge clk);
		check("hot", {28'h0, en}, 32'h0);
		rd(`PPM_ADDR_STATUS, 32'h8, 32'h8, 1'b0);
		temp <= 8'd130;
		wr(`PPM_ADDR_CTRL, 32'hF0);
		check("warm", {28'h0, en}, 32'h0);
		temp <= 8'd100;
		repeat (4) @(posedge clk);
		wr(`PPM_ADDR_CTRL, 32'hF0);
		check("cool", {28'h0, en}, 32'hF);
		$display("test thermal done");
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		check("reset en", {28'h0, en}, 32'h0);
		rd(`PPM_ADDR_REMAP, 32'hE4, 32'hFF, 1'b0);
		check("notes left", notes.size(), 32'h0);
		$display("test second reset done");
		close_out();
	end
endmodule : pse_port_power_manager_test
